// [pfc_params.svh]
// Timing constants and counter width for the protection fault controller.
// Assumes a 40 MHz system clock; included by the package, the tick generator and the controller.
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH

// ****************************************************************
// Timebase
// ****************************************************************
`define PFC_CLK_HZ          40000000
// Base tick period in microseconds; blanking and retry count ticks.
`define PFC_TICK_US         100
`define PFC_TICK_CYC        ((`PFC_CLK_HZ / 1000000) * `PFC_TICK_US)
// Blanking interval 20.7 ms, debounce interval 16.7 ms, in microseconds.
`define PFC_BLANK_US        20700
`define PFC_DEBOUNCE_US     16700
`define PFC_BLANK_TICKS     (`PFC_BLANK_US / `PFC_TICK_US)
`define PFC_DEBOUNCE_TICKS  ((`PFC_DEBOUNCE_US + `PFC_TICK_US - 1) / `PFC_TICK_US)
// Retry interval is fixed at thirty blanking intervals (621 ms nominal).
`define PFC_RETRY_RATIO     30
`define PFC_RETRY_TICKS     (`PFC_BLANK_TICKS * `PFC_RETRY_RATIO)
`define PFC_CNT_W           16

`endif

// [pfc_pkg.sv]
// Types shared by the protection fault controller modules.
// Assumes pfc_params.svh is on the include path.
`include "pfc_params.svh"

package pfc_pkg;

  // ****************************************************************
  // Overcurrent response variant
  // ****************************************************************
  typedef enum logic [1:0] {
    PFC_AUTORETRY  = 2'h0,
    PFC_LATCHOFF   = 2'h1,
    PFC_CONTINUOUS = 2'h2
  } pfc_variant_t;

  typedef enum logic [4:0] {
    PFC_ST_OFF     = 5'h01,
    PFC_ST_DEBNC   = 5'h02,
    PFC_ST_ON      = 5'h04,
    PFC_ST_RETRY   = 5'h08,
    PFC_ST_LATCHED = 5'h10
  } pfc_state_t;

endpackage : pfc_pkg

// [pfc_tick_gen.sv]
// Free-running timebase that pulses once per tick period.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_params.svh"

module pfc_tick_gen #(
  parameter int TICK_CYC = `PFC_TICK_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  import pfc_pkg::*;

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  always_comb begin
    if (cnt_q == 16'(TICK_CYC - 1)) begin
      cnt_d = 16'h0000;
    end else begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = (cnt_q == 16'(TICK_CYC - 1));

endmodule : pfc_tick_gen

`default_nettype wire

// [pfc_protection_fault_controller.sv]
// Fault-handling state machine of a power-path protection switch.
// Assumes comparator inputs are clean and synchronous to clk; rst is
// the input-supply power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_params.svh"

// What this block does
// - Overvoltage or undervoltage indication switches the FETs off.
// - Low lockout adjust pin selects the internal preset trip point.
// - Blanking timer starts on overcurrent, clears if overcurrent ends.
// - Flag goes low after overcurrent lasts the full blanking interval.
// - Autoretry: FETs off for retry interval after blanking, then on.
// - Autoretry: persistent overcurrent repeats cycle with flag held low.
// - Latch-off: overcurrent beyond blanking latches the switch off.
// - Latch-off: over-temperature latches off until enable toggle or reset.
// - Continuous: keep conducting, flag after blanking, release on removal.
// - Over-temperature turns switch off and flags; resumes after cooling except in latch-off.
// - Autoretry: after thermal shutdown wait a full retry interval.
// - Over-temperature acts immediately with no blanking delay.
// - Continuous: over-temperature switches off; back on after debounce once it clears.
// - Flag on blanking expiry, reverse trip, heat, grounded set, overvoltage.
// - Open set pin means zero limit; grounded set pin is a fault.
// - Reverse-flow enable disables reverse-current protection.
// - FETs turn on only after input above undervoltage for debounce.
// - Switch off only when high-voltage enable is 1 and enable is 0.
// - Retry interval is thirty blanking intervals from one timebase.
// - Debounce interval is about 16.7 ms.
module pfc_protection_fault_controller #(
  parameter pfc_pkg::pfc_variant_t VARIANT  = pfc_pkg::PFC_AUTORETRY,
  parameter int                    TICK_CYC = `PFC_TICK_CYC,
  parameter int                    BLANK_T  = `PFC_BLANK_TICKS,
  parameter int                    RETRY_T  = `PFC_RETRY_TICKS,
  parameter int                    DEBNC_T  = `PFC_DEBOUNCE_TICKS
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic overvoltage_lockout,
  input  wire logic undervoltage_lockout,
  input  wire logic ov_int_trip,
  input  wire logic uv_int_trip,
  input  wire logic ov_ext_trip,
  input  wire logic uv_ext_trip,
  input  wire logic overvoltage_lockout_adj_high,
  input  wire logic undervoltage_lockout_adj_high,
  input  wire logic over_current,
  input  wire logic over_temp,
  input  wire logic reverse_current,
  input  wire logic limit_set_open,
  input  wire logic limit_set_pin_gnd,
  input  wire logic reverse_flow_enable,
  input  wire logic hv_enable_n,
  input  wire logic enable,
  output logic      fet_on,
  output logic      limit_zero,
  output logic      flag_out,
  output logic      flag_oe,
  output logic      flag_n
);
  import pfc_pkg::*;

  // ****************************************************************
  // Input qualification
  // ****************************************************************
  logic tick;
  logic ov_act;
  logic uv_act;
  logic rev_trip;
  logic sw_en;
  logic hard_off;

  pfc_tick_gen #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  always_comb begin
    ov_act = overvoltage_lockout_adj_high ? ov_ext_trip : ov_int_trip;
    uv_act = undervoltage_lockout_adj_high ? uv_ext_trip : uv_int_trip;
    ov_act = ov_act | overvoltage_lockout;
    uv_act = uv_act | undervoltage_lockout;
    rev_trip = reverse_current & ~reverse_flow_enable;
    sw_en = ~(hv_enable_n & ~enable);
    hard_off = ov_act | uv_act | limit_set_pin_gnd | rev_trip | ~sw_en;
  end

  assign limit_zero = limit_set_open;

  // ****************************************************************
  // Fault state machine
  // ****************************************************************
  pfc_state_t             st_q;
  pfc_state_t             st_d;
  logic [`PFC_CNT_W-1:0]  blank_q;
  logic [`PFC_CNT_W-1:0]  blank_d;
  logic [`PFC_CNT_W-1:0]  tmr_q;
  logic [`PFC_CNT_W-1:0]  tmr_d;
  logic                   oc_flag_q;
  logic                   oc_flag_d;
  logic                   sw_en_q;
  logic                   blank_done;

  always_comb begin
    blank_d = blank_q;
    if (!over_current || st_q != PFC_ST_ON) begin
      blank_d = '0;
    end else if (tick && blank_q < `PFC_CNT_W'(BLANK_T)) begin
      blank_d = blank_q + `PFC_CNT_W'(1);
    end
  end
  assign blank_done = (blank_q == `PFC_CNT_W'(BLANK_T));

  always_comb begin
    st_d      = st_q;
    tmr_d     = tmr_q;
    oc_flag_d = oc_flag_q;
    case (st_q)
      PFC_ST_OFF: begin
        tmr_d = '0;
        if (!hard_off && !over_temp) begin
          st_d = PFC_ST_DEBNC;
        end
      end
      PFC_ST_DEBNC: begin
        if (hard_off || over_temp) begin
          st_d = PFC_ST_OFF;
        end else if (tmr_q > `PFC_CNT_W'(DEBNC_T)) begin
          st_d = PFC_ST_ON;
        end else if (tick) begin
          tmr_d = tmr_q + `PFC_CNT_W'(1);
        end
      end
      PFC_ST_ON: begin
        tmr_d = '0;
        if (!over_current && VARIANT != PFC_AUTORETRY) begin
          oc_flag_d = 1'b0;
        end
        if (hard_off) begin
          st_d      = PFC_ST_OFF;
          oc_flag_d = 1'b0;
        end else if (over_temp) begin
          if (VARIANT == PFC_LATCHOFF) begin
            st_d = PFC_ST_LATCHED;
          end else if (VARIANT == PFC_AUTORETRY) begin
            st_d = PFC_ST_RETRY;
          end else begin
            st_d = PFC_ST_OFF;
          end
        end else if (blank_done) begin
          oc_flag_d = 1'b1;
          if (VARIANT == PFC_AUTORETRY) begin
            st_d = PFC_ST_RETRY;
          end else if (VARIANT == PFC_LATCHOFF) begin
            st_d = PFC_ST_LATCHED;
          end
        end else if (!over_current && blank_q == '0) begin
          oc_flag_d = 1'b0;
        end
      end
      PFC_ST_RETRY: begin
        if (hard_off) begin
          st_d      = PFC_ST_OFF;
          oc_flag_d = 1'b0;
        end else if (over_temp) begin
          tmr_d = '0;
        end else if (tmr_q >= `PFC_CNT_W'(RETRY_T)) begin
          st_d  = PFC_ST_ON;
          tmr_d = '0;
        end else if (tick) begin
          tmr_d = tmr_q + `PFC_CNT_W'(1);
        end
      end
      PFC_ST_LATCHED: begin
        if (!sw_en && sw_en_q) begin
          st_d      = PFC_ST_OFF;
          oc_flag_d = 1'b0;
        end
      end
      default: begin
        st_d = PFC_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q      <= PFC_ST_OFF;
      blank_q   <= '0;
      tmr_q     <= '0;
      oc_flag_q <= 1'b0;
      sw_en_q   <= 1'b0;
    end else begin
      st_q      <= st_d;
      blank_q   <= blank_d;
      tmr_q     <= tmr_d;
      oc_flag_q <= oc_flag_d;
      sw_en_q   <= sw_en;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic fet_d;
  logic flag_d;
  logic fet_q;
  logic flag_q;

  // FET and flag outputs are registered so the gate driver never sees decode glitches.
  always_comb begin
    fet_d = (st_q == PFC_ST_ON) && !hard_off && !over_temp;
    flag_d = oc_flag_q | rev_trip | over_temp | limit_set_pin_gnd
           | ov_act | (st_q == PFC_ST_LATCHED);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fet_q  <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      fet_q  <= fet_d;
      flag_q <= flag_d;
    end
  end

  assign fet_on   = fet_q;
  assign flag_n   = ~flag_q;
  assign flag_out = 1'b0;
  assign flag_oe  = flag_q;

endmodule : pfc_protection_fault_controller

`default_nettype wire

// [pfc_source_model.sv]
// Far side: the protected load and the die temperature sense.
// Assumes the bench sets the load demand and the heat level.
`timescale 1ns/1ps
`default_nettype none
module pfc_source_model (
  input  wire logic overload,
  input  wire logic heat,
  output logic      over_current,
  output logic      over_temp
);
  // ********
  // Sensing
  // ********
  // The sense follows demand, so a short still present is seen again
  // in the very cycle the switch turns back on.
  assign over_current = overload;
  assign over_temp    = heat;
endmodule : pfc_source_model
`default_nettype wire

// [pfc_checker_properties.sv]
// Port checks for the fault controller, bound into every copy of it.
// Assumes one clock and the asynchronous supply reset rst.
`timescale 1ns/1ps
`default_nettype none
module pfc_checker #(
  parameter pfc_pkg::pfc_variant_t VARIANT  = pfc_pkg::PFC_AUTORETRY,
  parameter int                    TICK_CYC = 4,
  parameter int                    BLANK_T  = 3,
  parameter int                    RETRY_T  = 90,
  parameter int                    DEBNC_T  = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic overvoltage_lockout,
  input wire logic undervoltage_lockout,
  input wire logic over_current,
  input wire logic over_temp,
  input wire logic reverse_current,
  input wire logic limit_set_open,
  input wire logic limit_set_pin_gnd,
  input wire logic reverse_flow_enable,
  input wire logic hv_enable_n,
  input wire logic enable,
  input wire logic fet_on,
  input wire logic limit_zero,
  input wire logic flag_n
);
  import pfc_pkg::*;
  localparam int OC_MIN  = (BLANK_T - 1) * TICK_CYC;
  localparam int OC_MAX  = (BLANK_T + 1) * TICK_CYC + 2;
  localparam int RET_MIN = (RETRY_T - 1) * TICK_CYC;
  localparam int DEB_MIN = DEBNC_T * TICK_CYC;
  logic        rev_trip, hard;
  logic [15:0] oc_q, oc_d, cl_q, cl_d, off_q, off_d;
  // ********
  // Run lengths
  // ********
  // Preset trip inputs are left out, so hard is a subset and never false.
  always_comb begin
    rev_trip = reverse_current & ~reverse_flow_enable;
    hard = overvoltage_lockout | undervoltage_lockout | limit_set_pin_gnd
         | rev_trip | (hv_enable_n & ~enable);
    oc_d  = (over_current & fet_on) ? oc_q + {15'h0, ~&oc_q} : 16'h0;
    cl_d  = hard ? 16'h0 : cl_q + {15'h0, ~&cl_q};
    off_d = fet_on ? 16'h0 : off_q + {15'h0, ~&off_q};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {oc_q, cl_q, off_q} <= 48'h0;
    end else begin
      {oc_q, cl_q, off_q} <= {oc_d, cl_d, off_d};
    end
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_hard_off; hard |-> ##[1:2] !fet_on; endproperty
  a_hard_off: assert property (p_hard_off)
    else $error("switch on while locked out");
  property p_heat; over_temp |-> ##[1:2] (!fet_on && !flag_n); endproperty
  a_heat: assert property (p_heat)
    else $error("no immediate thermal shutdown");
  property p_flag_src;
    (overvoltage_lockout | limit_set_pin_gnd | rev_trip) |-> ##[1:2] !flag_n;
  endproperty
  a_flag_src: assert property (p_flag_src)
    else $error("fault flag missing");
  property p_limit; limit_zero == limit_set_open; endproperty
  a_limit: assert property (p_limit)
    else $error("zero limit request wrong");
  property p_blank_min;
    $fell(flag_n) && over_current |-> int'(oc_q) >= OC_MIN;
  endproperty
  a_blank_min: assert property (p_blank_min)
    else $error("flag before blanking ran out");
  property p_blank_max; int'(oc_q) == OC_MAX |-> !flag_n; endproperty
  a_blank_max: assert property (p_blank_max)
    else $error("flag late after blanking");
  property p_retry;
    VARIANT == PFC_AUTORETRY && $rose(fet_on) && !flag_n
      |-> int'(off_q) >= RET_MIN;
  endproperty
  a_retry: assert property (p_retry)
    else $error("retry interval cut short");
  property p_debounce; $rose(fet_on) |-> int'(cl_q) >= DEB_MIN; endproperty
  a_debounce: assert property (p_debounce)
    else $error("switch on before debounce");
  c_retry: cover property ($rose(fet_on) && !flag_n);
  c_blank: cover property ($fell(flag_n) && over_current);
  c_heat: cover property (over_temp && !fet_on);
endmodule : pfc_checker

bind pfc_protection_fault_controller pfc_checker #(
  .VARIANT(VARIANT), .TICK_CYC(TICK_CYC), .BLANK_T(BLANK_T),
  .RETRY_T(RETRY_T), .DEBNC_T(DEBNC_T)) u_chk (.*);
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the fault controller in its autoretry build.
// Assumes package, design, checker and source model compile first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pfc_pkg::*;
  // ********
  // Signals and helpers
  // ********
  logic clk = 1'b0;
  logic rst, overvoltage_lockout, undervoltage_lockout, ov_int_trip;
  logic uv_int_trip, ov_ext_trip, uv_ext_trip, overvoltage_lockout_adj_high, undervoltage_lockout_adj_high;
  logic over_current, over_temp, reverse_current, limit_set_open, enable;
  logic limit_set_pin_gnd, reverse_flow_enable, hv_enable_n, overload, heat;
  logic fet_on, limit_zero, flag_out, flag_oe, flag_n;
  logic [31:0] seed = 32'h25A3;
  logic [12:0] v;
  logic [1:0]  e;
  logic [12:0] rows [14] = '{13'h1001, 13'h0801, 13'h0401, 13'h0201,
    13'h0101, 13'h0141, 13'h00A1, 13'h0441, 13'h0011, 13'h0009, 13'h000D,
    13'h0002, 13'h0000, 13'h0003};
  int err_count = 0;
  int total_checks = 0;
  int cyc_n = 0;
  int i;
  pfc_protection_fault_controller #(.TICK_CYC(4), .BLANK_T(3),
    .RETRY_T(90), .DEBNC_T(2)) uut (.*);
  pfc_source_model model (.*);
  always #12.5 clk = ~clk;
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Expected {fet_on, flag_n} for a steady lockout and enable vector.
  function automatic logic [1:0] want(logic [12:0] x);
    logic tr;
    tr = x[12] | (x[6] ? x[8] : x[10]) | x[4] | (x[3] & ~x[2]);
    return {~(tr | x[11] | (x[5] ? x[7] : x[9]) | (x[1] & ~x[0])), ~tr};
  endfunction : want
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(logic got, logic exp, string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s is %b", $time, m, got);
    end
  endtask : chk
  task automatic wait_fet(logic exp, int max);
    int k;
    @(negedge clk);
    for (k = 0; k < max && fet_on !== exp; k++) @(negedge clk);
    chk(fet_on, exp, "fet_on");
  endtask : wait_fet
  task automatic set(logic [12:0] x);
    {overvoltage_lockout, undervoltage_lockout, ov_int_trip, uv_int_trip,
     ov_ext_trip, uv_ext_trip, overvoltage_lockout_adj_high, undervoltage_lockout_adj_high,
     limit_set_pin_gnd, reverse_current, reverse_flow_enable, hv_enable_n,
     enable} <= x;
  endtask : set
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // A hang costs a mismatch rather than an endless run.
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 6000) begin
      err_count++;
      give_verdict();
    end
  end
  // ********
  // Scenarios
  // ********
  initial begin
    rst = 1'b1;
    set(13'h0001);
    {overload, heat, limit_set_open} <= 3'h0;
    cyc(2);
    rst <= 1'b0;
    wait_fet(1'b1, 40);
    for (i = 0; i < 30; i++) begin
      seed = xs(seed);
      v = i < 14 ? rows[i] : seed[12:0];
      e = want(v);
      cyc(1);
      set(v);
      cyc(3);
      @(negedge clk);
      chk(fet_on, e[1], "fet_on");
      chk(flag_n, e[0], "flag_n");
      chk(flag_oe, ~e[0], "flag_oe");
      chk(flag_out, 1'b0, "flag_out");
      cyc(1);
      set(13'h0001);
      wait_fet(1'b1, 40);
    end
    repeat (6) begin
      seed = xs(seed);
      cyc(1);
      overload <= 1'b1;
      limit_set_open <= seed[0];
      cyc(1 + int'(seed[3:1]) % 6);
      overload <= 1'b0;
      cyc(4);
      @(negedge clk);
      chk(flag_n, 1'b1, "flag_n");
      chk(limit_zero, limit_set_open, "limit_zero");
    end
    cyc(1);
    overload <= 1'b1;
    wait_fet(1'b0, 30);
    cyc(1);
    @(negedge clk);
    chk(flag_n, 1'b0, "flag_n");
    wait_fet(1'b1, 400);
    chk(flag_n, 1'b0, "flag_n");
    wait_fet(1'b0, 30);
    cyc(1);
    overload <= 1'b0;
    wait_fet(1'b1, 400);
    cyc(4);
    @(negedge clk);
    chk(flag_n, 1'b1, "flag_n");
    cyc(1);
    heat <= 1'b1;
    cyc(2);
    @(negedge clk);
    chk(fet_on, 1'b0, "fet_on");
    chk(flag_n, 1'b0, "flag_n");
    cyc(20);
    heat <= 1'b0;
    cyc(300);
    @(negedge clk);
    chk(fet_on, 1'b0, "fet_on");
    wait_fet(1'b1, 100);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
